//--- bus_decode_defines.vh
`ifndef BUS_DECODE_DEFINES_VH
`define BUS_DECODE_DEFINES_VH
`define CLK_PERIOD_PS      8000
`define STROBE_MIN_NS      500
`define GUARD_MIN_NS       30
`define STROBE_CYCLES      ((`STROBE_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define GUARD_CYCLES       ((`GUARD_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define AREA_LSB           2
`define AREA_BITS          3
`define BASE_LSB           5
`define BASE_BITS          3
`endif

//--- sync3.v
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
   parameter W = 1
) (
   input  wire         core_clk_i,
   input  wire         sys_rst_i,
   input  wire [W-1:0] async_i,
   output reg  [W-1:0] level_o
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   // change accepted once stages two and three agree
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s1_q    <= {W{1'b0}};
         s2_q    <= {W{1'b0}};
         s3_q    <= {W{1'b0}};
         level_o <= {W{1'b0}};
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_o <= s3_q;
         end
      end
   end
endmodule // sync3
`default_nettype wire

//--- bus_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "bus_decode_defines.vh"
module bus_decode #(
   parameter AREAS = 8
) (
   input  wire                  core_clk_i,
   input  wire                  sys_rst_i,
   input  wire [7:0]            bus_addr_i,
   input  wire                  status_in_i,
   input  wire                  status_out_i,
   input  wire                  status_inta_i,
   input  wire                  pdbin_i,
   input  wire                  write_n_i,
   input  wire                  wait_mode_i,
   input  wire [`BASE_BITS-1:0] base_sel_i,
   input  wire [7:0]            bus_dout_i,
   input  wire [7:0]            board_data_i,
   output reg                   board_select_o,
   output reg                   chip_select_strobe_n_o,
   output reg  [AREAS-1:0]      group_select_n_o,
   output reg  [1:0]            port_sel_o,
   output reg                   dout_rcv_en_n_o,
   output reg                   din_drv_en_n_o,
   output reg  [7:0]            board_data_o,
   output reg  [7:0]            bus_din_o
);
   localparam [31:0] STB_W     = `STROBE_CYCLES;
   localparam [31:0] GUARD_W   = `GUARD_CYCLES;
   localparam [7:0]  STB_CNT   = STB_W[7:0];
   localparam [7:0]  GUARD_CNT = GUARD_W[7:0];
   localparam [1:0]  ST_IDLE   = 2'h0;
   localparam [1:0]  ST_LEAD   = 2'h1;
   localparam [1:0]  ST_STB    = 2'h2;
   localparam [1:0]  ST_TAIL   = 2'h3;

   wire [7:0]            addr_s;
   wire [7:0]            dout_s;
   wire [7:0]            bdat_s;
   wire [`BASE_BITS-1:0] base_s;
   wire                  in_s;
   wire                  out_s;
   wire                  inta_s;
   wire                  dbin_s;
   wire                  wr_n_s;
   wire                  wait_s;

   // every bus pin is asynchronous to the core clock
   sync3 #(
      .W(8)
   ) u_addr (
      .core_clk_i(core_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (bus_addr_i),
      .level_o   (addr_s)
   );
   sync3 #(
      .W(8)
   ) u_dout (
      .core_clk_i(core_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (bus_dout_i),
      .level_o   (dout_s)
   );
   sync3 #(
      .W(8)
   ) u_bdat (
      .core_clk_i(core_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (board_data_i),
      .level_o   (bdat_s)
   );
   sync3 #(
      .W(`BASE_BITS)
   ) u_base (
      .core_clk_i(core_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (base_sel_i),
      .level_o   (base_s)
   );
   // write strobe resets to active, harmless while hit is low
   sync3 #(
      .W(6)
   ) u_ctl (
      .core_clk_i(core_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   ({status_in_i, status_out_i, status_inta_i, pdbin_i, write_n_i, wait_mode_i}),
      .level_o   ({in_s, out_s, inta_s, dbin_s, wr_n_s, wait_s})
   );

   wire                  hit;
   wire [`AREA_BITS-1:0] area;
   wire [7:0]            stb_len;
   assign hit  = (in_s | out_s) & (addr_s[`BASE_LSB +: `BASE_BITS] == base_s);
   assign area = addr_s[`AREA_LSB +: `AREA_BITS];
   // strobe stretched by one 8 ns core clock mimics the inserted wait cycle
   assign stb_len = wait_s ? (STB_CNT + 8'h01) : STB_CNT;

   reg [1:0]       st_q;
   reg [1:0]       st_d;
   reg [7:0]       cnt_q;
   reg [7:0]       cnt_d;
   reg             sel_d;
   reg             stb_n_d;
   reg [AREAS-1:0] grp_n_d;
   reg [1:0]       port_d;
   reg             rcv_n_d;
   reg             drv_n_d;
   reg [7:0]       wdat_d;
   reg [7:0]       rdat_d;

   // limitation: pins must settle about four clocks before hit is seen
   // new hits wait until the tail guard has run out
   always @* begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      sel_d   = board_select_o;
      stb_n_d = chip_select_strobe_n_o;
      grp_n_d = group_select_n_o;
      port_d  = port_sel_o;
      case (st_q)
         ST_IDLE: begin
            if (hit) begin
               sel_d = 1'b1;
               cnt_d = GUARD_CNT;
               st_d  = ST_LEAD;
            end
         end
         ST_LEAD: begin
            if (cnt_q > 8'h01) begin
               cnt_d = cnt_q - 8'h01;
            end else begin
               stb_n_d = 1'b0;
               grp_n_d = ~({{(AREAS-1){1'b0}}, 1'b1} << area);
               port_d  = addr_s[1:0];
               cnt_d   = stb_len;
               st_d    = ST_STB;
            end
         end
         ST_STB: begin
            if (cnt_q > 8'h01) begin
               cnt_d = cnt_q - 8'h01;
            end else if (!hit) begin
               stb_n_d = 1'b1;
               grp_n_d = {AREAS{1'b1}};
               cnt_d   = GUARD_CNT;
               st_d    = ST_TAIL;
            end
         end
         ST_TAIL: begin
            if (cnt_q > 8'h01) begin
               cnt_d = cnt_q - 8'h01;
            end else begin
               sel_d = 1'b0;
               st_d  = ST_IDLE;
            end
         end
         default: begin
            st_d    = ST_IDLE;
            cnt_d   = 8'h00;
            sel_d   = 1'b0;
            stb_n_d = 1'b1;
            grp_n_d = {AREAS{1'b1}};
            port_d  = 2'h0;
         end
      endcase
   end

   // data path steering
   always @* begin
      rcv_n_d = ~(~wr_n_s & hit);
      drv_n_d = ~(dbin_s & ((in_s & hit) | inta_s));
      wdat_d  = dout_s;
      rdat_d  = bdat_s;
   end

   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_q                   <= ST_IDLE;
         cnt_q                  <= 8'h00;
         board_select_o         <= 1'b0;
         chip_select_strobe_n_o <= 1'b1;
         group_select_n_o       <= {AREAS{1'b1}};
         port_sel_o             <= 2'h0;
      end else begin
         st_q                   <= st_d;
         cnt_q                  <= cnt_d;
         board_select_o         <= sel_d;
         chip_select_strobe_n_o <= stb_n_d;
         group_select_n_o       <= grp_n_d;
         port_sel_o             <= port_d;
      end
   end

   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         dout_rcv_en_n_o <= 1'b1;
         din_drv_en_n_o  <= 1'b1;
         board_data_o    <= 8'h00;
         bus_din_o       <= 8'h00;
      end else begin
         dout_rcv_en_n_o <= rcv_n_d;
         din_drv_en_n_o  <= drv_n_d;
         board_data_o    <= wdat_d;
         bus_din_o       <= rdat_d;
      end
   end
endmodule // bus_decode
`default_nettype wire

//--- bus_decode_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bus_decode_chk #(parameter AREAS = 8) (
   input wire logic             core_clk_i,
   input wire logic             sys_rst_i,
   input wire logic             wait_mode_i,
   input wire logic             board_select_o,
   input wire logic             chip_select_strobe_n_o,
   input wire logic [AREAS-1:0] group_select_n_o,
   input wire logic [1:0]       port_sel_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire             cs_n = chip_select_strobe_n_o;
   wire             sel  = board_select_o;
   wire [AREAS-1:0] gn   = group_select_n_o;
   sel_lead_a: assert property ($fell(cs_n) |-> $past(sel, 4))
      else $error("select not ahead of strobe");
   sel_trail_a: assert property ($rose(cs_n) |-> sel [*4])
      else $error("select dropped too soon");
   strobe_sel_a: assert property (!cs_n |-> sel)
      else $error("strobe without select");
   width_two_a: assert property ($fell(cs_n) |-> ##62 !cs_n)
      else $error("strobe too short");
   width_wait_a: assert property ($fell(cs_n) && wait_mode_i |-> ##63 !cs_n)
      else $error("strobe lacks wait cycle");
   one_group_a: assert property ($onehot0(~gn))
      else $error("several groups active");
   idle_group_a: assert property (cs_n |-> &gn)
      else $error("group active without strobe");
   hold_area_a: assert property (!cs_n && $past(!cs_n) |-> $stable(gn) && $stable(port_sel_o))
      else $error("area moved during access");
endmodule // bus_decode_chk
bind bus_decode bus_decode_chk #(.AREAS(AREAS)) u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
   .wait_mode_i(wait_mode_i), .board_select_o(board_select_o), .chip_select_strobe_n_o(chip_select_strobe_n_o),
   .group_select_n_o(group_select_n_o), .port_sel_o(port_sel_o));
`default_nettype wire

//--- host_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module host_cpu (
   input  wire logic       core_clk_i,
   output var  logic [7:0] addr_o,
   output var  logic [7:0] dout_o,
   output var  logic       st_in_o,
   output var  logic       st_out_o,
   output var  logic       inta_o,
   output var  logic       pdbin_o,
   output var  logic       write_n_o
);
   initial begin
      {addr_o, dout_o, st_in_o, st_out_o, inta_o, pdbin_o} = '0;
      write_n_o = 1'b1;
   end
   task automatic cycle(input logic wr, ia, input logic [7:0] a, d);
      @(negedge core_clk_i);
      {addr_o, dout_o, write_n_o} = {a, d, !wr};
      {st_in_o, st_out_o, inta_o, pdbin_o} = {!wr && !ia, wr, ia, !wr};
      // held past strobe minimum plus sync and guard time
      repeat (80) @(negedge core_clk_i);
      // released address and data lines show the inverse, not the last value
      {addr_o, dout_o, write_n_o} = {~a, ~d, 1'b1};
      {st_in_o, st_out_o, inta_o, pdbin_o} = '0;
      repeat (16) @(negedge core_clk_i);
   endtask
endmodule // host_cpu
`default_nettype wire

//--- bus_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bus_decode_tb;
   logic        clk = 0, rst = 1, wm = 0, cs_d = 1, seen, wr;
   logic [2:0]  base = 0;
   logic [7:0]  bdi = 0, a, d;
   logic [19:0] exp_q[$];
   int          err_count = 0, tests_run = 0;
   wire  [7:0]  addr, dout, gn, bdo, bdin;
   wire  [1:0]  ps;
   wire         s_in, s_out, ia, pdbin, wn, sel, cs_n, dn, in_n;
   always #4 clk = ~clk;
   host_cpu u_host (.core_clk_i(clk), .addr_o(addr), .dout_o(dout), .st_in_o(s_in), .st_out_o(s_out),
      .inta_o(ia), .pdbin_o(pdbin), .write_n_o(wn));
   bus_decode u_dut (.core_clk_i(clk), .sys_rst_i(rst), .bus_addr_i(addr), .status_in_i(s_in),
      .status_out_i(s_out), .status_inta_i(ia), .pdbin_i(pdbin), .write_n_i(wn), .wait_mode_i(wm),
      .base_sel_i(base), .bus_dout_i(dout), .board_data_i(bdi), .board_select_o(sel),
      .chip_select_strobe_n_o(cs_n), .group_select_n_o(gn), .port_sel_o(ps), .dout_rcv_en_n_o(dn),
      .din_drv_en_n_o(in_n), .board_data_o(bdo), .bus_din_o(bdin));
   task chk(input logic [19:0] g, e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task stop_test;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one noted result per strobe; an unexpected strobe meets x
   always @(negedge clk) begin
      cs_d <= cs_n;
      if (sel) seen = 1;
      if (cs_d && !cs_n) chk({gn, ps, dn, in_n, dn ? bdin : bdo}, exp_q.size() ? exp_q.pop_front() : 'x);
   end
   initial begin
      #100000;
      err_count++;
      stop_test;
   end
   initial begin
      void'($urandom(64));
      repeat (8) @(negedge clk);
      rst = 0;
      for (int i = 0; i < 16; i++) begin
         {base, wm, wr, d, bdi} = 21'($urandom);
         a = {base, i[2:0], 2'($urandom)};
         exp_q.push_back({~(8'h1 << i[2:0]), a[1:0], !wr, wr, wr ? d : bdi});
         u_host.cycle(wr, 1'b0, a, d);
      end
      for (int j = 0; j < 2; j++) begin
         seen = 0;
         a = {~base, 5'($urandom)};
         fork
            u_host.cycle(1'b0, j[0], a, 8'h00);
            begin
               repeat (40) @(negedge clk);
               chk({10'h0, seen, in_n, j[0] ? bdin : 8'h0}, {10'h0, 1'b0, !j[0], j[0] ? bdi : 8'h0});
            end
         join
      end
      chk(20'(exp_q.size()), 20'h0);
      stop_test;
   end
endmodule // bus_decode_tb
`default_nettype wire
